// [rtl/rsq_consts.svh]
// Constants of the rail sequencer and reset timer.
// Notes on behaviour
// - Every turn-on that regulates in time gives the host an active-low reset pulse of 200ms.
// - Reset stays asserted for as long as the whole device is shut down.
// - One startup timer starts when the power node reaches battery voltage and also times the reset pulse.
// - Core alone not at 90% when 200ms expires: core rail shuts down.
// - After that timeout the node stays on while button or hold request.
// - Second enable high at startup: both rails must reach 90% in 200ms.
// - When all enabled rails regulate, the timer reloads a full 200ms.
// - Secondary rail runs only while core is enabled and in regulation.
// - Both enabled at power-up: secondary waits for core at 90%.
// - Core below 85% of its setting turns the secondary rail off.
// - A pin chosen by the host permits pulse skipping; never without it.
// - On battery, button low or hold request high turns on and keeps on.
// - Sensed external power enables core and charger regardless of buttons.
// - Rails turn on only after the power node reaches battery voltage.
// - Pulse skipping inhibited for 200ms after startup and on external power.
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define RSQ_CLK_MHZ 100
`define RSQ_TIMER_MS 200
`define RSQ_TICK_CYCLES `RSQ_CLK_MHZ
`define RSQ_TIMER_TICKS (`RSQ_TIMER_MS * 1000)

// ****************************************************************
// Register offsets
// ****************************************************************
`define RSQ_OFF_STATUS 12'h000
`define RSQ_OFF_MASK 12'h004
`define RSQ_OFF_CTRL 12'h008
`define RSQ_OFF_STATE 12'h00c

// ****************************************************************
// Status bit positions and reset values
// ****************************************************************
`define RSQ_EV_TIMEOUT 0
`define RSQ_EV_SEC_DROP 1
`define RSQ_EV_RST_DONE 2
`define RSQ_EV_EXT_PWR 3
`define RSQ_EV_W 4
`define RSQ_MASK_RST 4'h0
`define RSQ_CTRL_RST 1'h1

`endif

// [rtl/rsq_pkg.sv]
// Types shared by the rail sequencer design.
package rsq_pkg;

  typedef enum logic [5:0] {
    RSQ_OFF = 6'h01,
    RSQ_RAMP = 6'h02,
    RSQ_START = 6'h04,
    RSQ_HOLD = 6'h08,
    RSQ_RUN = 6'h10,
    RSQ_FAULT = 6'h20
  } rsq_state_e;

  typedef struct packed {
    logic button_n;
    logic hold_on_request;
    logic usb_sense;
    logic wall_power_sense;
    logic node_at_battery;
    logic core_at_90;
    logic core_above_85;
    logic second_at_90;
    logic second_rail_enable;
    logic skip_permit;
    logic light_load;
  } rsq_pins_s;

endpackage

// [rtl/rsq_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
`default_nettype none
module rsq_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule
`default_nettype wire

// [rtl/rsq_top.sv]
// Rail sequencer, reset timer and APB register file.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.svh"
module rsq_top
  import rsq_pkg::*;
#(
  parameter int P_TIMER_TICKS = `RSQ_TIMER_TICKS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Asynchronous pins and analog comparator flags
  input wire rsq_pins_s i_pins,
  // Power controls
  output logic o_reset_n,
  output logic o_node_on,
  output logic o_core_enable,
  output logic o_second_enable,
  output logic o_charger_enable,
  output logic o_pulse_skip,
  // Interrupt
  output logic o_irq
);

  // ****************************************************************
  // Synchronised inputs
  // ****************************************************************
  rsq_pins_s pins;
  logic [$bits(rsq_pins_s)-1:0] pins_sync;

  // The button idles high but the synchroniser resets low, so the button
  // travels inverted; otherwise reset release would look like a press.
  rsq_sync #(.W($bits(rsq_pins_s))) u_sync (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_async(i_pins ^ 11'h400),
    .o_sync(pins_sync)
  );

  assign pins = rsq_pins_s'(pins_sync ^ 11'h400);

  wire ext_power = pins.usb_sense | pins.wall_power_sense;
  wire user_on = ~pins.button_n | pins.hold_on_request;
  wire turn_on = user_on | ext_power;

  // ****************************************************************
  // Timebase and startup timer
  // ****************************************************************
  logic [6:0] div_ff;
  logic tick_ff;
  logic [23:0] timer_ff;
  logic [23:0] nxt_timer;
  logic timer_load;

  // The timer counts microsecond ticks so that its width stays small.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div_ff <= 7'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (div_ff == 7'(`RSQ_TICK_CYCLES - 1));
      div_ff <= (div_ff == 7'(`RSQ_TICK_CYCLES - 1)) ? 7'h00 : div_ff + 7'h01;
    end
  end

  wire timer_done = (timer_ff == 24'h000000);

  assign nxt_timer = timer_load ? 24'(P_TIMER_TICKS) :
                     (tick_ff && !timer_done) ? timer_ff - 24'h000001 :
                     timer_ff;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      timer_ff <= 24'h000000;
    else
      timer_ff <= nxt_timer;
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  rsq_state_e state_ff;
  rsq_state_e nxt_state;
  logic sec_req_ff;
  logic sec_on_ff;
  logic nxt_sec_on;

  wire regulated = pins.core_at_90 &
                   (~sec_req_ff | pins.second_at_90);

  always_comb
  begin
    nxt_state = state_ff;
    timer_load = 1'b0;
    case (state_ff)
      RSQ_OFF:
        if (turn_on)
          nxt_state = RSQ_RAMP;
      RSQ_RAMP:
        if (!turn_on)
          nxt_state = RSQ_OFF;
        else if (pins.node_at_battery)
        begin
          nxt_state = RSQ_START;
          timer_load = 1'b1;
        end
      RSQ_START:
        if (!turn_on)
          nxt_state = RSQ_OFF;
        else if (regulated)
        begin
          nxt_state = RSQ_HOLD;
          timer_load = 1'b1;
        end
        else if (timer_done)
          nxt_state = RSQ_FAULT;
      RSQ_HOLD:
        if (!turn_on)
          nxt_state = RSQ_OFF;
        else if (timer_done)
          nxt_state = RSQ_RUN;
      RSQ_RUN:
        if (!turn_on)
          nxt_state = RSQ_OFF;
      RSQ_FAULT:
        if (!user_on)
          nxt_state = RSQ_OFF;
      default:
        nxt_state = RSQ_OFF;
    endcase
  end

  // The second rail enable is latched at startup to pick the timeout test.
  wire core_live = (state_ff == RSQ_START) | (state_ff == RSQ_HOLD) |
                   (state_ff == RSQ_RUN);

  // Hysteresis: on at 90%, off below 85%, so a brief sag does not chatter.
  assign nxt_sec_on = core_live & pins.second_rail_enable &
                      (sec_on_ff ? pins.core_above_85 :
                       pins.core_at_90);

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_ff <= RSQ_OFF;
      sec_req_ff <= 1'b0;
      sec_on_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sec_on_ff <= nxt_sec_on;
      if (timer_load && state_ff == RSQ_RAMP)
        sec_req_ff <= pins.second_rail_enable;
    end
  end

  // ****************************************************************
  // Power outputs
  // ****************************************************************
  logic ctrl_skip_ff;

  wire nxt_reset_n = (state_ff == RSQ_RUN);
  wire nxt_node_on = (state_ff != RSQ_OFF);
  wire nxt_core_en = core_live;
  wire nxt_charger = ext_power & (state_ff != RSQ_OFF);
  wire nxt_skip = pins.skip_permit & pins.light_load & ~ext_power &
                  (state_ff == RSQ_RUN) & ctrl_skip_ff;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reset_n <= 1'b0;
      o_node_on <= 1'b0;
      o_core_enable <= 1'b0;
      o_second_enable <= 1'b0;
      o_charger_enable <= 1'b0;
      o_pulse_skip <= 1'b0;
    end
    else
    begin
      o_reset_n <= nxt_reset_n;
      o_node_on <= nxt_node_on;
      o_core_enable <= nxt_core_en;
      o_second_enable <= nxt_sec_on;
      o_charger_enable <= nxt_charger;
      o_pulse_skip <= nxt_skip;
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  logic [`RSQ_EV_W-1:0] status_ff;
  logic [`RSQ_EV_W-1:0] mask_ff;
  logic ext_d_ff;
  logic [`RSQ_EV_W-1:0] events;

  always_comb
  begin
    events = '0;
    events[`RSQ_EV_TIMEOUT] = (state_ff == RSQ_START) &
                              (nxt_state == RSQ_FAULT);
    events[`RSQ_EV_SEC_DROP] = sec_on_ff & ~nxt_sec_on;
    events[`RSQ_EV_RST_DONE] = (state_ff == RSQ_HOLD) &
                               (nxt_state == RSQ_RUN);
    events[`RSQ_EV_EXT_PWR] = ext_power & ~ext_d_ff;
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  wire setup = i_psel & ~i_penable;
  wire wr_en = i_psel & i_penable & o_pready & i_pwrite;
  wire hit_status = (i_paddr == `RSQ_OFF_STATUS);
  wire hit_mask = (i_paddr == `RSQ_OFF_MASK);
  wire hit_ctrl = (i_paddr == `RSQ_OFF_CTRL);
  wire hit_state = (i_paddr == `RSQ_OFF_STATE);
  wire mapped = hit_status | hit_mask | hit_ctrl | hit_state;
  wire [`RSQ_EV_W-1:0] w1c = (wr_en & hit_status) ?
                             i_pwdata[`RSQ_EV_W-1:0] : '0;
  wire [31:0] rd_data = hit_status ? {28'h0000000, status_ff} :
                        hit_mask ? {28'h0000000, mask_ff} :
                        hit_ctrl ? {31'h00000000, ctrl_skip_ff} :
                        hit_state ? {19'h00000, o_pulse_skip,
                                     o_charger_enable, o_second_enable,
                                     o_core_enable, o_node_on, o_reset_n,
                                     1'b0, state_ff} : 32'h00000000;

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status_ff <= '0;
      mask_ff <= `RSQ_MASK_RST;
      ctrl_skip_ff <= `RSQ_CTRL_RST;
      ext_d_ff <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      status_ff <= (status_ff & ~w1c) | events;
      ext_d_ff <= ext_power;
      o_irq <= |(((status_ff & ~w1c) | events) & mask_ff);
      if (wr_en && hit_mask)
        mask_ff <= i_pwdata[`RSQ_EV_W-1:0];
      if (wr_en && hit_ctrl)
        ctrl_skip_ff <= i_pwdata[0];
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
    else
    begin
      o_pready <= setup;
      o_pslverr <= setup & ~mapped;
      if (setup)
        o_prdata <= i_pwrite ? 32'h00000000 : rd_data;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_regulate;
    (state_ff == RSQ_START) && regulated && turn_on;
  endsequence

  sequence s_reload;
    (state_ff == RSQ_HOLD) && (timer_ff == 24'(P_TIMER_TICKS));
  endsequence

  AST_RST_SHUT: assert property (
    (state_ff == RSQ_OFF) |=> !o_reset_n)
    else $error("reset released while shut down");

  AST_RST_RUN: assert property (
    $rose(o_reset_n) |-> $past(state_ff) == RSQ_RUN)
    else $error("reset released outside run");

  AST_RELOAD: assert property (s_regulate |=> s_reload)
    else $error("timer not reloaded at regulation");

  AST_TIMEOUT: assert property (
    (state_ff == RSQ_START) && timer_done && !regulated && turn_on |=>
    state_ff == RSQ_FAULT ##1 !o_core_enable)
    else $error("no shutdown on startup timeout");

  AST_FAULT_NODE: assert property (
    (state_ff == RSQ_FAULT) && user_on |=> o_node_on)
    else $error("power node dropped during hold");

  AST_SEC_GATE: assert property (
    o_second_enable |-> o_core_enable)
    else $error("second rail on without core rail");

  AST_SEC_DROP: assert property (
    sec_on_ff && !pins.core_above_85 |=> !o_second_enable)
    else $error("second rail kept on after core sag");

  AST_SEC_WAIT: assert property (
    $rose(o_second_enable) |-> $past(pins.core_at_90))
    else $error("second rail on before core at 90 percent");

  AST_NODE_FIRST: assert property (
    (state_ff == RSQ_RAMP) && !pins.node_at_battery |=>
    !o_core_enable [*2])
    else $error("core rail on before power node ready");

  AST_SKIP_PIN: assert property (
    !pins.skip_permit || ext_power |=> !o_pulse_skip)
    else $error("pulse skipping while forbidden");

  AST_CHARGE: assert property (
    ext_power && (state_ff != RSQ_OFF) |=> o_charger_enable)
    else $error("charger off with external power");

endmodule
`default_nettype wire

// [testbench/rsq_host_model.sv]
// Host and rail plant model on the far side of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module rsq_host_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // From the sequencer
  input wire logic i_host_reset_n,
  input wire logic i_node_on,
  input wire logic i_core_en,
  input wire logic i_sec_en,
  // Scenario controls
  input wire logic i_claim,
  input wire logic i_weak_core,
  input wire logic i_weak_sec,
  input wire logic i_droop,
  // To the sequencer
  output logic o_hold,
  output logic o_node_bat,
  output logic o_core90,
  output logic o_core85,
  output logic o_sec90
);
  logic [3:0] node_ff;
  logic [3:0] core_ff;
  logic [3:0] sec_ff;
  logic hold_ff;

  // ****
  // Each supply takes eight cycles to ramp once its switch closes.
  // ****
  function automatic logic [3:0] ramp(input logic en, input logic [3:0] c);
    ramp = !en ? 4'h0 : (c == 4'h8) ? c : c + 4'h1;
  endfunction

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      node_ff <= 4'h0;
      core_ff <= 4'h0;
      sec_ff <= 4'h0;
      hold_ff <= 1'b0;
    end
    else
    begin
      node_ff <= ramp(i_node_on, node_ff);
      core_ff <= ramp(i_core_en, core_ff);
      sec_ff <= ramp(i_sec_en, sec_ff);
      // The host claims power only once its reset is released.
      hold_ff <= i_claim && (hold_ff || i_host_reset_n);
    end
  end

  assign o_hold = hold_ff;
  assign o_node_bat = node_ff == 4'h8;
  // A sag below 85 percent also takes the core below 90 percent.
  assign o_core85 = core_ff == 4'h8 && !i_droop;
  assign o_core90 = o_core85 && !i_weak_core;
  assign o_sec90 = sec_ff == 4'h8 && !i_weak_sec;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the rail sequencer and reset timer.
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.svh"
module tb
  import rsq_pkg::*;
;
  // Short timer keeps the run brief; all spans derive from it.
  localparam int TICKS = 20;
  localparam int PULSE = TICKS * `RSQ_TICK_CYCLES;
  // The prescaler phase at a timer load is free, so a span may end a tick
  // early.
  localparam int LOW = PULSE - `RSQ_TICK_CYCLES;
  localparam int RST = 0;
  localparam int NOD = 1;
  localparam int COR = 2;
  localparam int SEC = 3;
  localparam int SKP = 5;
  localparam int IRQ = 6;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic btn_n = 1'b1;
  logic usb = 1'b0;
  logic wall = 1'b0;
  logic sen = 1'b0;
  logic perm = 1'b0;
  logic light = 1'b0;
  logic claim = 1'b0;
  logic weak_c = 1'b0;
  logic weak_s = 1'b0;
  logic droop = 1'b0;
  logic hold, nbat, c90, c85, s90;
  logic rst_n, node, core, sec, chg, skip, irq;
  logic [6:0] outs;
  logic [31:0] rdata;
  logic rerr;
  int wn;
  int bad_count = 0;
  int comparisons = 0;
  rsq_pins_s pins;

  assign pins = '{btn_n, hold, usb, wall, nbat, c90, c85, s90, sen, perm,
    light};
  assign outs = {irq, skip, chg, sec, core, node, rst_n};

  always #5 i_clock = ~i_clock;

  rsq_top #(.P_TIMER_TICKS(TICKS)) i_dut (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pins(pins), .o_reset_n(rst_n),
    .o_node_on(node), .o_core_enable(core), .o_second_enable(sec),
    .o_charger_enable(chg), .o_pulse_skip(skip), .o_irq(irq));

  rsq_host_model i_host (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_host_reset_n(rst_n),
    .i_node_on(node), .i_core_en(core), .i_sec_en(sec), .i_claim(claim),
    .i_weak_core(weak_c), .i_weak_sec(weak_s), .i_droop(droop),
    .o_hold(hold), .o_node_bat(nbat), .o_core90(c90), .o_core85(c85),
    .o_sec90(s90));

  // ****
  // Tasks
  // ****
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task give_up(input string nm);
    bad_count++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    report_and_stop;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      give_up("pready");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask

  // Counts cycles in wn until the chosen output shows the value.
  task waitv(input int s, input logic v, input int lim);
    wn = 0;
    while (outs[s] !== v)
    begin
      @(posedge i_clock);
      wn++;
      if (wn > lim)
        give_up("output wait");
    end
  endtask

  always @(posedge i_clock)
  begin
    if (node === 1'b0)
      chk("reset in shutdown", 0, 32'(rst_n));
    if (core === 1'b1)
      chk("node ready", 1, 32'(nbat));
    if (rst_n === 1'b0)
      chk("skip at startup", 0, 32'(skip));
    if (sec === 1'b1)
      chk("second needs core", 1, 32'(core));
  end

  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (3) @(posedge i_clock);
    chk("outputs in reset", 0, 32'(outs));
    i_reset_n <= 1'b1;
    rdc("status", `RSQ_OFF_STATUS, 32'h0);
    rdc("mask", `RSQ_OFF_MASK, 32'h0);
    rdc("ctrl", `RSQ_OFF_CTRL, 32'h1);
    rdc("state", `RSQ_OFF_STATE, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 1, 32'(rerr));
    chk("unmapped data", 0, rdata);
    apb(1'b1, `RSQ_OFF_MASK, 32'hf);
    btn_n <= 1'b0;
    waitv(COR, 1'b1, 100);
    chk("charger off on battery", 0, 32'(chg));
    waitv(RST, 1'b1, PULSE + 100);
    chk("pulse", 1, 32'(wn >= LOW && wn <= PULSE + 60));
    rdc("state run", `RSQ_OFF_STATE, 32'h390);
    rdc("status done", `RSQ_OFF_STATUS, 32'h4);
    chk("irq raised", 1, 32'(irq));
    apb(1'b1, `RSQ_OFF_MASK, 32'h0);
    waitv(IRQ, 1'b0, 4);
    apb(1'b1, `RSQ_OFF_MASK, 32'hf);
    waitv(IRQ, 1'b1, 4);
    apb(1'b1, `RSQ_OFF_STATUS, 32'h4);
    waitv(IRQ, 1'b0, 4);
    claim <= 1'b1;
    repeat (5) @(posedge i_clock);
    btn_n <= 1'b1;
    repeat (20) @(posedge i_clock);
    chk("held on", 1, 32'(node));
    perm <= 1'b1;
    light <= 1'b1;
    waitv(SKP, 1'b1, 20);
    wall <= 1'b1;
    waitv(SKP, 1'b0, 20);
    wall <= 1'b0;
    waitv(SKP, 1'b1, 20);
    apb(1'b1, `RSQ_OFF_CTRL, 32'h0);
    waitv(SKP, 1'b0, 20);
    apb(1'b1, `RSQ_OFF_CTRL, 32'h1);
    waitv(SKP, 1'b1, 20);
    perm <= 1'b0;
    waitv(SKP, 1'b0, 20);
    light <= 1'b0;
    apb(1'b1, `RSQ_OFF_STATUS, 32'hf);
    sen <= 1'b1;
    waitv(SEC, 1'b1, 20);
    droop <= 1'b1;
    waitv(SEC, 1'b0, 10);
    rdc("status drop", `RSQ_OFF_STATUS, 32'h2);
    droop <= 1'b0;
    sen <= 1'b0;
    claim <= 1'b0;
    waitv(NOD, 1'b0, 50);
    weak_c <= 1'b1;
    btn_n <= 1'b0;
    waitv(COR, 1'b1, 100);
    waitv(COR, 1'b0, PULSE + 50);
    chk("timeout", 1, 32'(wn >= LOW && wn <= PULSE + 10));
    repeat (20) @(posedge i_clock);
    chk("node kept", 1, 32'(node));
    chk("reset in fault", 0, 32'(rst_n));
    apb(1'b0, `RSQ_OFF_STATUS, 32'h0);
    chk("timeout flag", 1, 32'(rdata[0]));
    btn_n <= 1'b1;
    waitv(NOD, 1'b0, 50);
    weak_c <= 1'b0;
    weak_s <= 1'b1;
    sen <= 1'b1;
    btn_n <= 1'b0;
    waitv(SEC, 1'b1, 100);
    chk("core first", 1, 32'(c90));
    waitv(COR, 1'b0, PULSE + 50);
    chk("both window", 1, 32'(wn >= LOW - 20 && wn <= PULSE + 10));
    btn_n <= 1'b1;
    waitv(NOD, 1'b0, 50);
    weak_s <= 1'b0;
    sen <= 1'b0;
    usb <= 1'b1;
    waitv(COR, 1'b1, 100);
    chk("charger ext", 1, 32'(chg));
    waitv(RST, 1'b1, PULSE + 100);
    usb <= 1'b0;
    waitv(NOD, 1'b0, 50);
    report_and_stop;
  end
endmodule
`default_nettype wire
